// ### rtl/ilrb_defs.svh
// offsets, field layouts, reset values and fixed figures of the input limit bank
`ifndef ILRB_DEFS_SVH
`define ILRB_DEFS_SVH

// register byte offsets on the serial port
`define ILRB_OFS_VIN_LO 8'h0A
`define ILRB_OFS_VIN_HI 8'h0B
`define ILRB_OFS_HOST_LO 8'h0E
`define ILRB_OFS_HOST_HI 8'h0F
`define ILRB_OFS_APPL_LO 8'h24
`define ILRB_OFS_APPL_HI 8'h25

// reset values
`define ILRB_HOST_HI_RST 8'h40
`define ILRB_HOST_LO_RST 8'h00
`define ILRB_APPL_RST 7'h00
`define ILRB_VIN_RST 8'h00

// field layouts
`define ILRB_HOST_RSVD_BIT 7
`define ILRB_HOST_CODE_MSB 6
`define ILRB_VIN_HI_RSVD_MASK 8'hC0
`define ILRB_VIN_HI_FIELD_MASK 8'h3F
`define ILRB_VIN_LO_FIELD_MASK 8'hC0

// voltage limit arithmetic, in mV
`define ILRB_VIN_BASE_MV 16'h0C80
`define ILRB_VIN_STEP_SHIFT 6
`define ILRB_VIN_DEFAULT_DROP_MV 16'h0500

// serial byte framing
`define ILRB_BITS_PER_BYTE 4'h8

`endif

// ### rtl/ilrb_pkg.sv
// types shared by the input limit bank modules
package ilrb_pkg;

  // serial engine states, gray coded along the usual path
  typedef enum logic [3:0]
  {
    ILRB_IDLE      = 4'b0000,
    ILRB_ADDR      = 4'b0001,
    ILRB_ADDR_ACK  = 4'b0011,
    ILRB_PTR       = 4'b0010,
    ILRB_PTR_ACK   = 4'b0110,
    ILRB_WDATA     = 4'b0111,
    ILRB_WDATA_ACK = 4'b0101,
    ILRB_RDATA     = 4'b0100,
    ILRB_RDATA_ACK = 4'b1100
  } ilrb_state_t;

  typedef logic [7:0] ilrb_byte_t;
  typedef logic [6:0] ilrb_icode_t;
  typedef logic [15:0] ilrb_mv_t;

endpackage

// ### rtl/ilrb_reg_if.sv
// byte access channel between the serial engine and the register store
`timescale 1ns/1ns
interface ilrb_reg_if;
  import ilrb_pkg::*;
  logic wr_stb;        // one-cycle byte write strobe
  ilrb_byte_t addr;    // register pointer
  ilrb_byte_t wdata;   // byte being written
  ilrb_byte_t rdata;   // byte at the pointer

  modport engine
  (
    output wr_stb,
    output addr,
    output wdata,
    input rdata
  );

  modport store
  (
    input wr_stb,
    input addr,
    input wdata,
    output rdata
  );
endinterface

// ### rtl/ilrb_limit_store.sv
// register store: host current limit, input voltage limit, readback decode
`timescale 1ns/1ns
`include "ilrb_defs.svh"
module ilrb_limit_store
(
  input wire logic clk,
  input wire logic rst_n,
  ilrb_reg_if.store bus,
  input wire logic adapter_present,
  input wire ilrb_pkg::ilrb_icode_t applied_code,
  output ilrb_pkg::ilrb_icode_t host_code,
  output ilrb_pkg::ilrb_byte_t vin_code,
  output logic vin_written
);
  import ilrb_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  ilrb_byte_t host_hi_reg;      // host current limit upper byte
  ilrb_byte_t vin_hi_reg;       // committed voltage limit upper byte
  ilrb_byte_t vin_lo_reg;       // committed voltage limit lower byte
  ilrb_byte_t vin_lo_stage_reg; // lower byte held until upper byte lands
  logic vin_written_reg;        // host has programmed the voltage limit
  logic adapter_prev_reg;       // adapter level one cycle ago

  // ****************************************
  // decode
  // ****************************************
  wire hit_vin_lo = bus.addr == `ILRB_OFS_VIN_LO;
  wire hit_vin_hi = bus.addr == `ILRB_OFS_VIN_HI;
  wire hit_host_hi = bus.addr == `ILRB_OFS_HOST_HI;
  wire hit_appl_hi = bus.addr == `ILRB_OFS_APPL_HI;
  // a one in a "not used" upper bit marks the whole byte invalid
  wire host_bad = bus.wdata[`ILRB_HOST_RSVD_BIT]; // R03
  wire vin_bad = |(bus.wdata & `ILRB_VIN_HI_RSVD_MASK);
  wire wr_host = bus.wr_stb && hit_host_hi && !host_bad;
  wire wr_vin_lo = bus.wr_stb && hit_vin_lo;
  wire wr_vin_hi = bus.wr_stb && hit_vin_hi && !vin_bad;
  wire adapter_gone = adapter_prev_reg && !adapter_present;

  // reserved bits read as zero; the host low byte ignores writes
  assign bus.rdata = hit_vin_lo ? (vin_lo_reg & `ILRB_VIN_LO_FIELD_MASK) : // R17
                     hit_vin_hi ? (vin_hi_reg & `ILRB_VIN_HI_FIELD_MASK) :
                     hit_host_hi ? {1'b0, host_hi_reg[`ILRB_HOST_CODE_MSB:0]} :
                     hit_appl_hi ? {1'b0, applied_code} : // R05
                     8'h00; // R04 R09

  assign host_code = host_hi_reg[`ILRB_HOST_CODE_MSB:0]; // R01
  assign vin_code = {vin_hi_reg[5:0], vin_lo_reg[7:6]}; // R14
  assign vin_written = vin_written_reg;

  // ****************************************
  // host current limit
  // ****************************************
  // adapter removal wins over a host write in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n || adapter_gone)
      host_hi_reg <= `ILRB_HOST_HI_RST; // R02 R15
    else if (wr_host)
      host_hi_reg <= {1'b0, bus.wdata[`ILRB_HOST_CODE_MSB:0]};
    adapter_prev_reg <= rst_n && adapter_present;
  end

  // ****************************************
  // voltage limit, committed as one 16-bit word
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      vin_lo_stage_reg <= `ILRB_VIN_RST;
      vin_lo_reg <= `ILRB_VIN_RST;
      vin_hi_reg <= `ILRB_VIN_RST;
      vin_written_reg <= 1'b0;
    end
    else
    begin
      // low byte only stages; regulation still sees the old word
      if (wr_vin_lo)
        vin_lo_stage_reg <= bus.wdata & `ILRB_VIN_LO_FIELD_MASK; // R16
      // upper byte commits both halves at once
      if (wr_vin_hi)
      begin
        vin_hi_reg <= bus.wdata; // R10 R16
        vin_lo_reg <= vin_lo_stage_reg;
        vin_written_reg <= 1'b1; // R12
      end
    end
  end

endmodule // ilrb_limit_store

// ### rtl/ilrb_input_limit_regs.sv
// input limit register bank with its serial slave port
//
// Behaviour
// R01: host current code in upper bits 6..0
// R02: host upper byte resets to bit 6 set
// R03: host keeps unused bit 7 at zero
// R04: host lower byte reserved, read-only, zero
// R05: separate readback of applied current limit
// R06: optimizer limit may override host limit
// R07: readback uses host current bit weights
// R08: code zero means fifty mA offset
// R09: readback bytes read-only, reset to zero
// R10: host writes voltage limit as 16 bits
// R11: input below limit enters power management
// R12: unwritten limit is no-load minus 1.28 V
// R13: voltage code zero means 3.2 V base
// R14: voltage field bits and weights, rest reserved
// R15: adapter removal restores default current limit
// R16: apply 16-bit value after both bytes
// R17: reserved bits always read as zero
`timescale 1ns/1ns
`include "ilrb_defs.svh"
module ilrb_input_limit_regs
#(
  // serial slave address; value is arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h2A
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic adapter_present,
  input wire logic optimizer_active,
  input wire ilrb_pkg::ilrb_icode_t optimizer_limit_code,
  input wire ilrb_pkg::ilrb_mv_t input_supply_voltage_mv,
  input wire ilrb_pkg::ilrb_mv_t noload_supply_voltage_mv,
  output ilrb_pkg::ilrb_icode_t host_input_current_limit_code,
  output ilrb_pkg::ilrb_icode_t applied_input_current_limit_code,
  output ilrb_pkg::ilrb_mv_t min_input_voltage_limit_mv,
  output logic dynamic_power_management_active
);
  import ilrb_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  ilrb_reg_if rif (); // engine to store channel

  ilrb_state_t state_reg;   // serial engine state
  ilrb_state_t state_next;
  logic scl_prev_reg;       // clock level last cycle
  logic sda_prev_reg;       // data level last cycle
  logic [3:0] bit_cnt_reg;  // bits moved in the current byte
  logic [3:0] bit_cnt_next;
  ilrb_byte_t shift_reg;    // receive shifter
  ilrb_byte_t shift_next;
  ilrb_byte_t tx_reg;       // transmit shifter
  ilrb_byte_t tx_next;
  ilrb_byte_t ptr_reg;      // register pointer, auto-increments
  ilrb_byte_t ptr_next;
  logic oe_reg;             // pulling data low
  logic oe_next;
  logic nack_reg;           // master refused the last read byte
  logic nack_next;
  logic wr_stb_reg;         // byte write strobe to the store
  logic wr_stb_next;
  ilrb_byte_t wdata_reg;    // byte handed to the store
  ilrb_byte_t wdata_next;
  ilrb_icode_t applied_reg; // current limit actually in force
  ilrb_mv_t vin_limit_reg;  // voltage limit actually in force
  logic dpm_reg;            // power management engaged
  ilrb_icode_t host_code;   // host code from the store
  ilrb_byte_t vin_code;     // committed voltage field
  logic vin_written;        // voltage limit programmed

  // ****************************************
  // bus condition detection
  // ****************************************
  // pins arrive synchronous, so plain edge compares are safe
  wire scl_rise = scl_in && !scl_prev_reg;
  wire scl_fall = !scl_in && scl_prev_reg;
  wire start_cond = scl_in && scl_prev_reg && sda_prev_reg && !sda_in;
  wire stop_cond = scl_in && scl_prev_reg && !sda_prev_reg && sda_in;
  wire byte_done = bit_cnt_reg == `ILRB_BITS_PER_BYTE;
  wire addr_match = shift_reg[7:1] == DEV_ADDR;
  wire [7:0] ptr_plus = ptr_reg + 8'h01;

  // ****************************************
  // serial engine next state
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    nack_next = nack_reg;
    wr_stb_next = 1'b0;
    wdata_next = wdata_reg;
    // receive bits on every rising clock while taking a byte
    if (scl_rise && (state_reg == ILRB_ADDR || state_reg == ILRB_PTR
                     || state_reg == ILRB_WDATA) && !byte_done)
    begin
      shift_next = {shift_reg[6:0], sda_in};
      bit_cnt_next = bit_cnt_reg + 4'h1;
    end
    // start and stop override everything, even mid byte
    if (start_cond)
    begin
      state_next = ILRB_ADDR;
      bit_cnt_next = 4'h0;
      oe_next = 1'b0;
    end
    else if (stop_cond)
    begin
      state_next = ILRB_IDLE;
      oe_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        ILRB_IDLE:
          // wait for a start
          oe_next = 1'b0;
        ILRB_ADDR:
          // address byte: acknowledge only our own address
          if (scl_fall && byte_done)
          begin
            if (addr_match)
            begin
              state_next = ILRB_ADDR_ACK;
              oe_next = 1'b1;
            end
            else
              state_next = ILRB_IDLE;
          end
        ILRB_ADDR_ACK:
          // after the ack either start sending or take the pointer
          if (scl_fall)
          begin
            if (shift_reg[0])
            begin
              state_next = ILRB_RDATA;
              oe_next = !rif.rdata[7];
              tx_next = {rif.rdata[6:0], 1'b0};
              bit_cnt_next = 4'h1;
            end
            else
            begin
              state_next = ILRB_PTR;
              oe_next = 1'b0;
              bit_cnt_next = 4'h0;
            end
          end
        ILRB_PTR:
          // register pointer byte
          if (scl_fall && byte_done)
          begin
            ptr_next = shift_reg;
            state_next = ILRB_PTR_ACK;
            oe_next = 1'b1;
          end
        ILRB_PTR_ACK:
          if (scl_fall)
          begin
            state_next = ILRB_WDATA;
            oe_next = 1'b0;
            bit_cnt_next = 4'h0;
          end
        ILRB_WDATA:
          // every data byte is acked; the store decides what sticks
          if (scl_fall && byte_done)
          begin
            wr_stb_next = 1'b1;
            wdata_next = shift_reg;
            state_next = ILRB_WDATA_ACK;
            oe_next = 1'b1;
          end
        ILRB_WDATA_ACK:
          // pointer moves only after the strobe has used it
          if (scl_fall)
          begin
            ptr_next = ptr_plus;
            state_next = ILRB_WDATA;
            oe_next = 1'b0;
            bit_cnt_next = 4'h0;
          end
        ILRB_RDATA:
          // shift the byte out msb first on falling clock
          if (scl_fall)
          begin
            if (byte_done)
            begin
              state_next = ILRB_RDATA_ACK;
              oe_next = 1'b0;
              ptr_next = ptr_plus;
            end
            else
            begin
              oe_next = !tx_reg[7];
              tx_next = {tx_reg[6:0], 1'b0};
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
          end
        ILRB_RDATA_ACK:
        begin
          // master ack keeps the read going, nack ends it
          if (scl_rise)
            nack_next = sda_in;
          if (scl_fall)
          begin
            if (nack_reg)
              state_next = ILRB_IDLE;
            else
            begin
              state_next = ILRB_RDATA;
              oe_next = !rif.rdata[7];
              tx_next = {rif.rdata[6:0], 1'b0};
              bit_cnt_next = 4'h1;
            end
          end
        end
        default:
          // unknown encodings fall back to idle
          state_next = ILRB_IDLE;
      endcase
    end
  end

  // ****************************************
  // serial engine registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ILRB_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      oe_reg <= 1'b0;
      nack_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      wdata_reg <= 8'h00;
      scl_prev_reg <= 1'b1; // idle bus is high, so no false start after reset
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      nack_reg <= nack_next;
      wr_stb_reg <= wr_stb_next;
      wdata_reg <= wdata_next;
      scl_prev_reg <= scl_in; // pin history for edge and condition detection
      sda_prev_reg <= sda_in;
    end
  end

  // ****************************************
  // channel to the store
  // ****************************************
  assign rif.wr_stb = wr_stb_reg;
  assign rif.addr = ptr_reg;
  assign rif.wdata = wdata_reg;

  ilrb_limit_store u_store
  (
    .clk(clk),
    .rst_n(rst_n),
    .bus(rif.store),
    .adapter_present(adapter_present),
    .applied_code(applied_reg),
    .host_code(host_code),
    .vin_code(vin_code),
    .vin_written(vin_written)
  );

  // ****************************************
  // limits in force
  // ****************************************
  // optimizer result replaces the host value while it is active;
  // the code keeps the 50 mA offset, so code 0 still means 50 mA
  wire [6:0] applied_next = optimizer_active ? optimizer_limit_code : host_code; // R06 R07 R08
  // programmed limit: 3.2 V base plus 64 mV per code step
  wire [15:0] vin_prog_mv = `ILRB_VIN_BASE_MV
                            + {2'b00, vin_code, 6'h00}; // R13 R14
  // default tracks the no-load supply; clamp so it never wraps
  wire vin_low_supply = noload_supply_voltage_mv < `ILRB_VIN_DEFAULT_DROP_MV;
  wire [15:0] vin_dflt_mv = vin_low_supply ? 16'h0000
                            : noload_supply_voltage_mv - `ILRB_VIN_DEFAULT_DROP_MV;
  wire [15:0] vin_limit_next = vin_written ? vin_prog_mv : vin_dflt_mv; // R12

  // limits are registered so each output comes from a flop
  always_ff @(posedge clk)
  begin
    sda_out <= 1'b0; // open drain: the pin is only ever pulled low
    if (!rst_n)
    begin
      applied_reg <= `ILRB_APPL_RST; // R09
      vin_limit_reg <= 16'h0000;
      dpm_reg <= 1'b0;
    end
    else
    begin
      applied_reg <= applied_next; // R05
      vin_limit_reg <= vin_limit_next;
      // compare against last cycle's limit; one cycle of lag is harmless
      dpm_reg <= input_supply_voltage_mv < vin_limit_reg; // R11
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign sda_oe = oe_reg;
  assign host_input_current_limit_code = host_code;
  assign applied_input_current_limit_code = applied_reg;
  assign min_input_voltage_limit_mv = vin_limit_reg;
  assign dynamic_power_management_active = dpm_reg;

endmodule // ilrb_input_limit_regs

// ### testbench/ilrb_input_limit_regs_properties.sv
// port checker for the input limit register bank
`timescale 1ns/1ns
module ilrb_input_limit_regs_properties
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic adapter_present,
  input wire logic optimizer_active,
  input wire ilrb_pkg::ilrb_icode_t optimizer_limit_code,
  input wire ilrb_pkg::ilrb_mv_t input_supply_voltage_mv,
  input wire ilrb_pkg::ilrb_mv_t noload_supply_voltage_mv,
  input wire ilrb_pkg::ilrb_icode_t host_input_current_limit_code,
  input wire ilrb_pkg::ilrb_icode_t applied_input_current_limit_code,
  input wire ilrb_pkg::ilrb_mv_t min_input_voltage_limit_mv,
  input wire logic dynamic_power_management_active
);
  import ilrb_pkg::*;
  // ****************
  // helper history
  // ****************
  logic [2:0] scl_h; // scl seen on the last three edges
  logic [2:0] ad_h; // adapter seen on the last three edges
  // no reset: history only feeds checks that are off in reset
  always_ff @(posedge clk)
  begin
    scl_h <= {scl_h[1:0], scl_in};
    ad_h <= {ad_h[1:0], adapter_present};
  end
  wire scl_fell2 = scl_h[2] & ~scl_h[1]; // byte write lands two edges later
  wire ad_fell = (ad_h[0] & ~adapter_present) | (ad_h[1] & ~ad_h[0]) | (ad_h[2] & ~ad_h[1]);
  // source of the applied limit
  wire ilrb_icode_t src = optimizer_active ? optimizer_limit_code : host_input_current_limit_code;
  // default limit, clamped at zero for low supplies
  wire ilrb_mv_t dflt = (noload_supply_voltage_mv >= 16'h0500) ?
    noload_supply_voltage_mv - 16'h0500 : 16'h0000;
  wire ilrb_mv_t lim = min_input_voltage_limit_mv;
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_host_reset_value: assert property (
    $rose(rst_n) |-> host_input_current_limit_code == 7'h40) else $error("host code reset");
  a_readback_reset_zero: assert property (
    $rose(rst_n) |-> applied_input_current_limit_code == 7'h00 && !sda_oe)
    else $error("readback reset");
  a_applied_source: assert property (
    $past(rst_n) |-> applied_input_current_limit_code == $past(src)) else $error("applied");
  a_host_change_cause: assert property (
    $changed(host_input_current_limit_code) |-> scl_fell2 || ad_fell) else $error("host change");
  a_adapter_restore: assert property (
    $fell(adapter_present) |-> ##[1:3] host_input_current_limit_code == 7'h40)
    else $error("adapter restore");
  a_power_mgmt_compare: assert property (
    ($stable(input_supply_voltage_mv) && $stable(lim))[*3] |->
    dynamic_power_management_active == (input_supply_voltage_mv < lim)) else $error("dpm");
  a_limit_default: assert property (
    $rose(rst_n) |=> lim == $past(dflt)) else $error("default limit");
  a_limit_grid: assert property (
    $past(rst_n) && $changed(lim) |-> lim == $past(dflt) ||
    (lim[5:0] == 6'h00 && lim >= 16'h0C80 && lim <= 16'h4C40)) else $error("limit grid");
  a_oe_after_fall: assert property (
    $changed(sda_oe) |-> scl_h[1] && !scl_h[0] && !sda_out) else $error("sda timing");
  // main scenarios seen
  c_adapter: cover property ($fell(adapter_present));
  c_dpm: cover property ($rose(dynamic_power_management_active));
  c_host: cover property ($changed(host_input_current_limit_code));
endmodule // ilrb_input_limit_regs_properties

bind ilrb_input_limit_regs ilrb_input_limit_regs_properties ilrb_props_inst (.*);

// ### testbench/ilrb_i2c_host_model.sv
// serial host controller model driving the bank's slave port
`timescale 1ns/1ns
module ilrb_i2c_host_model
#(
  parameter logic [6:0] ADDR = 7'h2A // slave address; value is arbitrary
)
(
  input wire logic clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_m
);
  import ilrb_pkg::*;
  int nacks; // bytes the slave failed to acknowledge
  // bus idles high through the pull-up
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
    nacks = 0;
  end
  // ****************
  // bit and byte level
  // ****************
  // four clocks per half keeps well over the two-cycle minimum
  task automatic tick();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    tick();
    scl = 1'b1;
    tick();
    r = sda_w;
    scl = 1'b0;
  endtask
  // ack bit: 1 releases the line, 0 acks a read byte
  task automatic xfer(input ilrb_byte_t d, input logic ackb, output ilrb_byte_t q,
    output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ackb, a);
  endtask
  task automatic send(input ilrb_byte_t d);
    ilrb_byte_t q;
    logic a;
    xfer(d, 1'b1, q, a);
    if (a)
      nacks++;
  endtask
  task automatic start();
    sda_m = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_m = 1'b0;
    tick();
    scl = 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_m = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_m = 1'b1;
    tick();
  endtask
  // ****************
  // register access
  // ****************
  // bit 7 of d0 is left to the caller; the bench only sets it on purpose
  task automatic wr(input ilrb_byte_t p, input ilrb_byte_t d0, input ilrb_byte_t d1,
    input logic two);
    start();
    send({ADDR, 1'b0});
    send(p);
    send(d0);
    if (two)
      send(d1);
    stop();
  endtask
  // single byte read ending in a nack
  task automatic rd(input ilrb_byte_t p, output ilrb_byte_t q);
    logic a;
    start();
    send({ADDR, 1'b0});
    send(p);
    start();
    send({ADDR, 1'b1});
    xfer(8'hFF, 1'b1, q, a);
    stop();
  endtask
endmodule // ilrb_i2c_host_model

// ### testbench/ilrb_input_limit_regs_tb_top.sv
// self-checking bench for the input limit register bank
`timescale 1ns/1ns
module ilrb_input_limit_regs_tb_top;
  import ilrb_pkg::*;
  // ****************
  // signals
  // ****************
  logic clk;
  logic rst_n;
  logic scl_in;
  logic sda_m; // host model's drive, 1 = released
  logic sda_out;
  logic sda_oe;
  wire sda_in = sda_oe ? 1'b0 : sda_m; // open drain with pull-up
  logic adapter_present;
  logic optimizer_active;
  ilrb_icode_t optimizer_limit_code;
  ilrb_icode_t host_input_current_limit_code;
  ilrb_icode_t applied_input_current_limit_code;
  ilrb_mv_t input_supply_voltage_mv;
  ilrb_mv_t noload_supply_voltage_mv;
  ilrb_mv_t min_input_voltage_limit_mv;
  logic dynamic_power_management_active;
  int failures;
  int n_compared;
  ilrb_input_limit_regs ilrb_input_limit_regs_inst (.*);
  ilrb_i2c_host_model host (.clk(clk), .sda_w(sda_in), .scl(scl_in), .sda_m(sda_m));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****************
  // helpers
  // ****************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rr(input ilrb_byte_t p, input ilrb_byte_t e);
    ilrb_byte_t q;
    host.rd(p, q);
    chk($sformatf("reg %h", p), 16'(e), 16'(q));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    chk("host code", 16'h0040, 16'(host_input_current_limit_code));
    rr(8'h0F, 8'h40);
    rr(8'h0E, 8'h00);
    rr(8'h24, 8'h00);
    rr(8'h25, 8'h40);
    chk("vin limit", 16'h0E88, min_input_voltage_limit_mv);
    $display("test reset done");
  endtask
  // boundary codes, then writes that must be dropped
  task automatic t_host();
    ilrb_byte_t v[3] = '{8'h05, 8'h7F, 8'h00};
    foreach (v[i])
    begin
      host.wr(8'h0F, v[i], 8'h00, 1'b0);
      rr(8'h0F, v[i]);
      rr(8'h25, v[i]);
    end
    host.wr(8'h0F, 8'h85, 8'h00, 1'b0);
    rr(8'h0F, 8'h00);
    host.wr(8'h0E, 8'hFF, 8'h00, 1'b0);
    host.wr(8'h24, 8'hFF, 8'h11, 1'b1);
    rr(8'h0E, 8'h00);
    rr(8'h24, 8'h00);
    rr(8'h25, 8'h00);
    $display("test host limit done");
  endtask
  task automatic t_optim();
    host.wr(8'h0F, 8'h05, 8'h00, 1'b0);
    optimizer_limit_code = 7'h33;
    optimizer_active = 1'b1;
    cyc(2);
    rr(8'h25, 8'h33);
    rr(8'h0F, 8'h05);
    optimizer_limit_code = 7'h00;
    rr(8'h25, 8'h00);
    optimizer_active = 1'b0;
    rr(8'h25, 8'h05);
    $display("test optimizer done");
  endtask
  task automatic t_vin();
    host.wr(8'h0A, 8'hFF, 8'h00, 1'b0);
    chk("half write", 16'h0E88, min_input_voltage_limit_mv);
    rr(8'h0A, 8'h00);
    host.wr(8'h0B, 8'h3F, 8'h00, 1'b0);
    chk("max limit", 16'h4C40, min_input_voltage_limit_mv);
    rr(8'h0A, 8'hC0);
    rr(8'h0B, 8'h3F);
    host.wr(8'h0A, 8'h00, 8'h00, 1'b1);
    chk("zero code", 16'h0C80, min_input_voltage_limit_mv);
    host.wr(8'h0B, 8'h41, 8'h00, 1'b0);
    chk("bad write", 16'h0C80, min_input_voltage_limit_mv);
    host.wr(8'h0A, 8'h40, 8'h01, 1'b1);
    chk("code five", 16'h0DC0, min_input_voltage_limit_mv);
    $display("test voltage limit done");
  endtask
  task automatic t_dpm();
    input_supply_voltage_mv = 16'h0DBF;
    cyc(2);
    chk("dpm below", 16'h0001, 16'(dynamic_power_management_active));
    input_supply_voltage_mv = 16'h0DC0;
    cyc(2);
    chk("dpm at limit", 16'h0000, 16'(dynamic_power_management_active));
    $display("test power management done");
  endtask
  task automatic t_adapter();
    adapter_present = 1'b0;
    cyc(3);
    chk("unplug", 16'h0040, 16'(host_input_current_limit_code));
    adapter_present = 1'b1;
    rr(8'h0F, 8'h40);
    chk("acks", 16'h0000, 16'(host.nacks));
    $display("test adapter done");
  endtask
  // foreign address is ignored; a two-byte read walks the pointer
  task automatic t_bus();
    ilrb_byte_t q0;
    ilrb_byte_t q1;
    logic a;
    host.start();
    host.send(8'h56); // foreign address
    host.send(8'h0F);
    host.stop();
    chk("foreign nacks", 16'h0002, 16'(host.nacks));
    rr(8'h0F, 8'h40);
    host.wr(8'h0F, 8'h21, 8'h00, 1'b0);
    host.start();
    host.send(8'h54);
    host.send(8'h24);
    host.start();
    host.send(8'h55);
    host.xfer(8'hFF, 1'b0, q0, a);
    host.xfer(8'hFF, 1'b1, q1, a);
    host.stop();
    chk("burst low", 16'h0000, 16'(q0));
    chk("burst high", 16'h0021, 16'(q1));
    $display("test bus done");
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************
  // main sequence and watchdog
  // ****************
  initial
  begin
    failures = 0;
    n_compared = 0;
    rst_n = 1'b0;
    adapter_present = 1'b1;
    optimizer_active = 1'b0;
    optimizer_limit_code = 7'h00;
    input_supply_voltage_mv = 16'h1388;
    noload_supply_voltage_mv = 16'h1388;
    cyc(2);
    rst_n = 1'b1;
    cyc(1);
    t_reset();
    t_host();
    t_optim();
    t_vin();
    t_dpm();
    t_adapter();
    t_bus();
    finish_test();
  end
  // the run needs some 11600 cycles; this stops a hang at 50000
  initial
  begin
    #2_000_000;
    failures++;
    finish_test();
  end
endmodule // ilrb_input_limit_regs_tb_top
